//--- logic/counter_run_ctrl.v
// Overview of operation
// R1: Bit 7 gates channel ten counter group
// R2: Channel ten event, noise counters never halted
// R3: Bits 6..4 run channels five, four, three
// R4: Bit 3 runs both second counters jointly
// R5: Bits 2..0 run chan two/one first, zero
// R6: First register RW, cleared by reset, standby
// R7: Second register bits run channel seven/six counters
// R8: Second register RW, cleared by reset, standby
// R9: Third register bit 0 runs channel eleven
// R10: Third register bits 7..1 read zero
// R11: Software writes zero to reserved bits
// R12: Third register cleared by reset, standby
// R13: Halted counter holds value, resumes later
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "run_ctrl_defs.vh"

module counter_run_ctrl #(
	parameter ADDR_W = 4
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [ADDR_W-1:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	output reg err_o,
	// Standby modes
	input wire hw_standby_i,
	input wire sw_standby_i,
	// Channel ten enables
	output reg run_chan_ten_group_o,
	output reg chan_ten_event_counter_en_o,
	output reg chan_ten_noise_filter_counter_en_o,
	// Channels zero to five enables
	output reg run_chan_five_o,
	output reg run_chan_four_o,
	output reg run_chan_three_o,
	output reg run_chan_one_second_o,
	output reg run_chan_two_second_o,
	output reg run_chan_two_first_o,
	output reg run_chan_one_first_o,
	output reg run_chan_zero_o,
	// Channels six and seven enables
	output reg run_chan_seven_d_o,
	output reg run_chan_seven_c_o,
	output reg run_chan_seven_b_o,
	output reg run_chan_seven_a_o,
	output reg run_chan_six_d_o,
	output reg run_chan_six_c_o,
	output reg run_chan_six_b_o,
	output reg run_chan_six_a_o,
	// Channel eleven enable
	output reg run_chan_eleven_o
);

	localparam [23:0] WMASKS = {`RUN_CTRL_THIRD_WMASK, `RUN_CTRL_SECOND_WMASK,
		`RUN_CTRL_FIRST_WMASK};

	wire [1:0] index;
	wire upper_zero;
	wire mapped;
	wire req;
	wire standby;
	wire [23:0] regs_q;
	wire [7:0] first_q;
	wire [7:0] second_q;
	wire [7:0] third_q;
	reg [2:0] reg_we;
	reg [7:0] next_rdata;
	// Next values of the channel ten and channels zero to five enables
	reg next_run_chan_ten_group;
	reg next_chan_ten_event_counter_en;
	reg next_chan_ten_noise_filter_counter_en;
	reg next_run_chan_five;
	reg next_run_chan_four;
	reg next_run_chan_three;
	reg next_run_chan_one_second;
	reg next_run_chan_two_second;
	reg next_run_chan_two_first;
	reg next_run_chan_one_first;
	reg next_run_chan_zero;
	// Next values of the channels six, seven and eleven enables
	reg next_run_chan_seven_d;
	reg next_run_chan_seven_c;
	reg next_run_chan_seven_b;
	reg next_run_chan_seven_a;
	reg next_run_chan_six_d;
	reg next_run_chan_six_c;
	reg next_run_chan_six_b;
	reg next_run_chan_six_a;
	reg next_run_chan_eleven;

	assign index = adr_i[3:2];

	// Address bits above the register index must be clear
	generate
		if (ADDR_W > 4)
		begin : g_wide_adr
			assign upper_zero = ~|adr_i[ADDR_W-1:4];
		end
		else
		begin : g_narrow_adr
			assign upper_zero = 1'b1;
		end
	endgenerate

	// Index three and unaligned addresses are unmapped
	assign mapped = upper_zero && (index != 2'h3) && (adr_i[1:0] == 2'b00);
	assign req = cyc_i && stb_i && !ack_o && !err_o;
	assign standby = hw_standby_i || sw_standby_i;

	// Write strobes per register, low byte lane only
	always @*
	begin
		reg_we = 3'b000;
		if (req && we_i && mapped && sel_i[0] && !standby)
		begin
			case (index)
				`RUN_CTRL_FIRST_IDX: reg_we = 3'b001;
				`RUN_CTRL_SECOND_IDX: reg_we = 3'b010;
				`RUN_CTRL_THIRD_IDX: reg_we = 3'b100;
				default: reg_we = 3'b000;
			endcase
		end
	end

	// Start registers, cleared while in either standby mode
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1)
		begin : g_reg
			start_reg #(
				.WRITE_MASK(WMASKS[8*i+7:8*i])
			) u_reg (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.clear_i(standby), // [R6] [R8] [R12]
				.we_i(reg_we[i]),
				.wdata_i(dat_i[7:0]), // [R11]
				.q_o(regs_q[8*i+7:8*i])
			);
		end
	endgenerate

	assign first_q = regs_q[7:0];
	assign second_q = regs_q[15:8];
	assign third_q = regs_q[23:16];

	// Read data select
	always @*
	begin
		next_rdata = 8'h00;
		case (index)
			`RUN_CTRL_FIRST_IDX: next_rdata = first_q; // [R6]
			`RUN_CTRL_SECOND_IDX: next_rdata = second_q; // [R8]
			`RUN_CTRL_THIRD_IDX: next_rdata = {7'h00, third_q[`RUN_CHAN_ELEVEN_BIT]}; // [R10]
			default: next_rdata = 8'h00;
		endcase
	end

	// Bus answer: one cycle after the request
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= req && mapped;
			err_o <= req && !mapped;
			if (req && mapped && !we_i)
				dat_o <= {24'h000000, next_rdata};
			else
				dat_o <= 32'h00000000;
		end
	end

	// Next enables from the start register bits
	always @*
	begin
		// Channel ten group; event and noise counters always run
		next_run_chan_ten_group = first_q[`RUN_CHAN_TEN_GROUP_BIT]; // [R1] [R13]
		next_chan_ten_event_counter_en = 1'b1; // [R2]
		next_chan_ten_noise_filter_counter_en = 1'b1; // [R2]

		// Channels zero to five
		next_run_chan_five = first_q[`RUN_CHAN_FIVE_BIT]; // [R3]
		next_run_chan_four = first_q[`RUN_CHAN_FOUR_BIT]; // [R3]
		next_run_chan_three = first_q[`RUN_CHAN_THREE_BIT]; // [R3]
		next_run_chan_one_second = first_q[`RUN_CHAN_ONE_TWO_SECOND_BIT]; // [R4]
		next_run_chan_two_second = first_q[`RUN_CHAN_ONE_TWO_SECOND_BIT]; // [R4]
		next_run_chan_two_first = first_q[`RUN_CHAN_TWO_FIRST_BIT]; // [R5]
		next_run_chan_one_first = first_q[`RUN_CHAN_ONE_FIRST_BIT]; // [R5]
		next_run_chan_zero = first_q[`RUN_CHAN_ZERO_BIT]; // [R5]

		// Channels six and seven
		next_run_chan_seven_d = second_q[`RUN_CHAN_SEVEN_D_BIT]; // [R7]
		next_run_chan_seven_c = second_q[`RUN_CHAN_SEVEN_C_BIT]; // [R7]
		next_run_chan_seven_b = second_q[`RUN_CHAN_SEVEN_B_BIT]; // [R7]
		next_run_chan_seven_a = second_q[`RUN_CHAN_SEVEN_A_BIT]; // [R7]
		next_run_chan_six_d = second_q[`RUN_CHAN_SIX_D_BIT]; // [R7]
		next_run_chan_six_c = second_q[`RUN_CHAN_SIX_C_BIT]; // [R7]
		next_run_chan_six_b = second_q[`RUN_CHAN_SIX_B_BIT]; // [R7]
		next_run_chan_six_a = second_q[`RUN_CHAN_SIX_A_BIT]; // [R7]

		// Channel eleven
		next_run_chan_eleven = third_q[`RUN_CHAN_ELEVEN_BIT]; // [R9] [R12]
	end

	// Channel ten enables; a low enable freezes the counter in place
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			run_chan_ten_group_o <= 1'b0;
			chan_ten_event_counter_en_o <= 1'b0;
			chan_ten_noise_filter_counter_en_o <= 1'b0;
		end
		else
		begin
			run_chan_ten_group_o <= next_run_chan_ten_group; // [R1] [R13]
			chan_ten_event_counter_en_o <= next_chan_ten_event_counter_en; // [R2]
			chan_ten_noise_filter_counter_en_o <= next_chan_ten_noise_filter_counter_en; // [R2]
		end
	end

	// Channels zero to five enables
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			run_chan_five_o <= 1'b0;
			run_chan_four_o <= 1'b0;
			run_chan_three_o <= 1'b0;
			run_chan_one_second_o <= 1'b0;
			run_chan_two_second_o <= 1'b0;
			run_chan_two_first_o <= 1'b0;
			run_chan_one_first_o <= 1'b0;
			run_chan_zero_o <= 1'b0;
		end
		else
		begin
			run_chan_five_o <= next_run_chan_five; // [R3]
			run_chan_four_o <= next_run_chan_four; // [R3]
			run_chan_three_o <= next_run_chan_three; // [R3]
			run_chan_one_second_o <= next_run_chan_one_second; // [R4]
			run_chan_two_second_o <= next_run_chan_two_second; // [R4]
			run_chan_two_first_o <= next_run_chan_two_first; // [R5]
			run_chan_one_first_o <= next_run_chan_one_first; // [R5]
			run_chan_zero_o <= next_run_chan_zero; // [R5]
		end
	end

	// Channels six and seven enables
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			run_chan_seven_d_o <= 1'b0;
			run_chan_seven_c_o <= 1'b0;
			run_chan_seven_b_o <= 1'b0;
			run_chan_seven_a_o <= 1'b0;
			run_chan_six_d_o <= 1'b0;
			run_chan_six_c_o <= 1'b0;
			run_chan_six_b_o <= 1'b0;
			run_chan_six_a_o <= 1'b0;
		end
		else
		begin
			run_chan_seven_d_o <= next_run_chan_seven_d; // [R7]
			run_chan_seven_c_o <= next_run_chan_seven_c; // [R7]
			run_chan_seven_b_o <= next_run_chan_seven_b; // [R7]
			run_chan_seven_a_o <= next_run_chan_seven_a; // [R7]
			run_chan_six_d_o <= next_run_chan_six_d; // [R7]
			run_chan_six_c_o <= next_run_chan_six_c; // [R7]
			run_chan_six_b_o <= next_run_chan_six_b; // [R7]
			run_chan_six_a_o <= next_run_chan_six_a; // [R7]
		end
	end

	// Channel eleven enable
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			run_chan_eleven_o <= 1'b0;
		end
		else
		begin
			run_chan_eleven_o <= next_run_chan_eleven; // [R9] [R12]
		end
	end

endmodule // counter_run_ctrl

`default_nettype wire

//--- common/run_ctrl_defs.vh
`ifndef RUN_CTRL_DEFS_VH
`define RUN_CTRL_DEFS_VH

// Register byte offsets
`define RUN_CTRL_FIRST_OFS 4'h0
`define RUN_CTRL_SECOND_OFS 4'h4
`define RUN_CTRL_THIRD_OFS 4'h8

// Register indices on the word address
`define RUN_CTRL_FIRST_IDX 2'h0
`define RUN_CTRL_SECOND_IDX 2'h1
`define RUN_CTRL_THIRD_IDX 2'h2

// Reset value of every start register
`define RUN_CTRL_RESET 8'h00

// Writable bits per register
`define RUN_CTRL_FIRST_WMASK 8'hff
`define RUN_CTRL_SECOND_WMASK 8'hff
`define RUN_CTRL_THIRD_WMASK 8'h01

// First register fields
`define RUN_CHAN_TEN_GROUP_BIT 7
`define RUN_CHAN_FIVE_BIT 6
`define RUN_CHAN_FOUR_BIT 5
`define RUN_CHAN_THREE_BIT 4
`define RUN_CHAN_ONE_TWO_SECOND_BIT 3
`define RUN_CHAN_TWO_FIRST_BIT 2
`define RUN_CHAN_ONE_FIRST_BIT 1
`define RUN_CHAN_ZERO_BIT 0

// Second register fields
`define RUN_CHAN_SEVEN_D_BIT 7
`define RUN_CHAN_SEVEN_C_BIT 6
`define RUN_CHAN_SEVEN_B_BIT 5
`define RUN_CHAN_SEVEN_A_BIT 4
`define RUN_CHAN_SIX_D_BIT 3
`define RUN_CHAN_SIX_C_BIT 2
`define RUN_CHAN_SIX_B_BIT 1
`define RUN_CHAN_SIX_A_BIT 0

// Third register field
`define RUN_CHAN_ELEVEN_BIT 0

`endif

//--- logic/start_reg.v
`timescale 1ns/10ps
`default_nettype none
`include "run_ctrl_defs.vh"

module start_reg #(
	parameter [7:0] WRITE_MASK = 8'hff
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Control
	input wire clear_i,
	input wire we_i,
	input wire [7:0] wdata_i,
	// State
	output reg [7:0] q_o
);

	always @(posedge clk_i)
	begin
		if (rst_i || clear_i)
			q_o <= `RUN_CTRL_RESET;
		else if (we_i)
			q_o <= (wdata_i & WRITE_MASK) | (q_o & ~WRITE_MASK);
	end

endmodule // start_reg

`default_nettype wire

//--- sim/counter_run_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module counter_run_ctrl_checker #(
	parameter ADDR_W = 4
) (
	// Clock and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic err_o,
	// Standby and enables
	input wire logic hw_standby_i,
	input wire logic sw_standby_i,
	input wire logic run_chan_ten_group_o,
	input wire logic chan_ten_event_counter_en_o,
	input wire logic run_chan_one_second_o,
	input wire logic run_chan_two_second_o,
	input wire logic run_chan_zero_o,
	input wire logic run_chan_eleven_o
);
	wire tk = cyc_i & stb_i & !ack_o & !err_o;
	wire ok = adr_i[1:0] == 2'h0 && adr_i[3:2] != 2'h3;
	wire wr = tk & ok & we_i & sel_i[0] & !hw_standby_i & !sw_standby_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_group_write: assert property (wr && adr_i[3:2] == 2'h0 |=> ##1
		run_chan_ten_group_o == $past(dat_i[7], 2)) else $error("group enable");
	a_event_on: assert property (!$past(rst_i) |-> chan_ten_event_counter_en_o)
		else $error("event enable");
	a_second_pair: assert property (run_chan_one_second_o == run_chan_two_second_o)
		else $error("second pair");
	a_zero_write: assert property (wr && adr_i[3:2] == 2'h0 |=> ##1
		run_chan_zero_o == $past(dat_i[0], 2)) else $error("zero enable");
	a_eleven_write: assert property (wr && adr_i[3:2] == 2'h2 |=> ##1
		run_chan_eleven_o == $past(dat_i[0], 2)) else $error("eleven enable");
	a_third_read: assert property (tk && !we_i && adr_i == 4'h8 |=>
		ack_o && dat_o[31:1] == 31'h0) else $error("third read");
	a_standby_clear: assert property ((hw_standby_i || sw_standby_i)[*2] |=>
		!run_chan_ten_group_o && !run_chan_zero_o && !run_chan_eleven_o) else $error("standby");
	a_err_unmapped: assert property (tk && !ok |=> err_o && !ack_o) else $error("unmapped");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack length");
	cover property (wr && adr_i[3:2] == 2'h2);
	cover property (err_o);
	cover property (sw_standby_i && tk && we_i);
endmodule // counter_run_ctrl_checker
bind counter_run_ctrl counter_run_ctrl_checker #(.ADDR_W(ADDR_W)) chk_i (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .hw_standby_i(hw_standby_i),
	.sw_standby_i(sw_standby_i), .run_chan_ten_group_o(run_chan_ten_group_o),
	.chan_ten_event_counter_en_o(chan_ten_event_counter_en_o),
	.run_chan_one_second_o(run_chan_one_second_o), .run_chan_two_second_o(run_chan_two_second_o),
	.run_chan_zero_o(run_chan_zero_o), .run_chan_eleven_o(run_chan_eleven_o));
`default_nettype wire

//--- sim/counter_run_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module counter_run_ctrl_tb;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, hw = 0, sw = 0;
	logic [3:0] adr_i = 0, sel_i = 0, a;
	logic [31:0] dat_i = 0;
	wire [31:0] dat_o;
	wire ack_o, err_o;
	wire [19:0] en;
	logic [32:0] q[$];
	logic [7:0] m[3] = '{default: 8'h00};
	int n_mismatch = 0, checks = 0, cnt = 0;
	counter_run_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.hw_standby_i(hw), .sw_standby_i(sw), .chan_ten_event_counter_en_o(en[19]),
		.chan_ten_noise_filter_counter_en_o(en[18]), .run_chan_ten_group_o(en[17]),
		.run_chan_five_o(en[16]), .run_chan_four_o(en[15]), .run_chan_three_o(en[14]),
		.run_chan_one_second_o(en[13]), .run_chan_two_second_o(en[12]),
		.run_chan_two_first_o(en[11]), .run_chan_one_first_o(en[10]), .run_chan_zero_o(en[9]),
		.run_chan_seven_d_o(en[8]), .run_chan_seven_c_o(en[7]), .run_chan_seven_b_o(en[6]),
		.run_chan_seven_a_o(en[5]), .run_chan_six_d_o(en[4]), .run_chan_six_c_o(en[3]),
		.run_chan_six_b_o(en[2]), .run_chan_six_a_o(en[1]), .run_chan_eleven_o(en[0]));
	initial forever #50 clk_i = ~clk_i;
	task test_done;
		if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic bus(input bit w, input logic [3:0] d_a, input logic [7:0] d, input bit s);
		bit ok;
		ok = d_a[1:0] == 2'h0 && d_a[3:2] != 2'h3;
		q.push_back({!ok, 24'h0, (ok && !w) ? m[d_a[3:2]] : 8'h00});
		if (ok && w && s && !(hw | sw)) m[d_a[3:2]] = d_a[3] ? d & 8'h01 : d;
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= d_a;
		dat_i <= {24'($urandom), d};
		sel_i <= {3'($urandom), s};
		@(posedge clk_i);
		while (ack_o !== 1'b1 && err_o !== 1'b1) @(posedge clk_i);
		cyc_i <= 0;
		stb_i <= 0;
		@(posedge clk_i);
	endtask
	task chk;
		logic [19:0] e;
		e = {2'b11, m[0][7:3], m[0][3:0], m[1], m[2][0]};
		checks++;
		if (en !== e)
		begin
			n_mismatch++;
			$display("Error %0t %h %h", $time, en, e);
		end
	endtask
	always @(posedge clk_i)
	begin
		if ((ack_o | err_o) === 1'b1)
		begin
			checks++;
			if (q.size() == 0 || {err_o, dat_o} !== q[0])
			begin
				n_mismatch++;
				$display("Error %0t %h %h", $time, {err_o, dat_o}, q[0]);
			end
			void'(q.pop_front());
		end
		if (++cnt > 3000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	initial
	begin
		void'($urandom(32'hf366ca3c));
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		for (int i = 0; i < 3; i++) bus(0, 4'(i * 4), 8'h00, 1);
		chk();
		for (int k = 0; k < 30; k++)
		begin
			a = 4'((k % 3) * 4);
			bus(1, a, a[3] ? 8'($urandom % 2) : 8'($urandom), k % 7 != 3);
			bus(0, a, 8'h00, 1);
			chk();
		end
		bus(1, 4'hc, 8'hff, 1);
		bus(0, 4'h1, 8'h00, 1);
		for (int i = 0; i < 2; i++)
		begin
			for (int j = 0; j < 3; j++) bus(1, 4'(j * 4), 8'hff, 1);
			{hw, sw} <= 2'(i + 1);
			repeat (3) @(posedge clk_i);
			m = '{default: 8'h00};
			bus(1, 4'h0, 8'h5a, 1);
			chk();
			{hw, sw} <= 2'h0;
			@(posedge clk_i);
		end
		bus(1, 4'h0, 8'hff, 1);
		rst_i <= 1;
		@(posedge clk_i);
		rst_i <= 0;
		repeat (2) @(posedge clk_i);
		m = '{default: 8'h00};
		chk();
		test_done();
	end
endmodule // counter_run_ctrl_tb
`default_nettype wire
